// ==== iep_consts.svh ====
// Purpose: Offsets, field positions, masks and reset values for the
//          interrupt enable and priority register block.
// Assumes: 16-bit register words on a plain strobe port.
// Notes:   Definitions only.
`ifndef IEP_CONSTS_SVH
`define IEP_CONSTS_SVH

// ----------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------
`define IEP_ADDR_W 4
`define IEP_DATA_W 16
`define IEP_NSRC 17
`define IEP_NPRI 5

// ----------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------
`define IEP_OFS_IEN5 4'h0
`define IEP_OFS_IEN6 4'h1
`define IEP_OFS_PRI0 4'h2
`define IEP_OFS_PRI1 4'h3
`define IEP_OFS_PRI2 4'h4
`define IEP_OFS_PRI3 4'h5
`define IEP_OFS_PRI4 4'h6

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define IEP_BIT_SER3_ERR 1
`define IEP_BIT_GFX 4
`define IEP_FLD0_LSB 0
`define IEP_FLD1_LSB 4
`define IEP_FLD2_LSB 8
`define IEP_FLD3_LSB 12

// ----------------------------------------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------------------------------------
`define IEP_MASK_IEN5 16'h0002
`define IEP_MASK_IEN6 16'h0010
`define IEP_MASK_PRI0 16'h7777
`define IEP_MASK_PRI1 16'h7770
`define IEP_MASK_PRI2 16'h7777
`define IEP_MASK_PRI3 16'h0077
`define IEP_MASK_PRI4 16'h7777
`define IEP_RST_PRI0 16'h4444
`define IEP_RST_PRI1 16'h4440
`define IEP_RST_PRI2 16'h4444
`define IEP_RST_PRI3 16'h0044
`define IEP_RST_PRI4 16'h4444
`define IEP_PRI_RST 3'h4
`define IEP_PRI_OFF 3'h0
`define IEP_PRI_TOP 3'h7

`endif

// ==== iep_pkg.sv ====
// Purpose: Types shared by the interrupt enable and priority block.
// Assumes: Source numbering follows the priority register fields.
// Notes:   Source enum order is the tie-break order (lower wins).
package iep_pkg;
    typedef logic [2:0] iep_level_t;
    typedef logic [4:0] iep_src_t;
    typedef enum logic [4:0] {
        IEP_EXT0, IEP_CAPT1, IEP_CMP1, IEP_TMR1,
        IEP_CAPT2, IEP_CMP2, IEP_TMR2,
        IEP_TMR3, IEP_SPORT1_FAULT, IEP_SPORT1_EVT, IEP_SER1_RX,
        IEP_SER1_TX, IEP_CONV_DONE,
        IEP_I2C1_SLV, IEP_I2C1_MST, IEP_COMPARATOR, IEP_CHANGE_NOTIFY
    } iep_src_id_t;
endpackage

// ==== iep_req_if.sv ====
// Purpose: Qualified requests and levels from the gate to the arbiter.
// Assumes: Single clock domain, no timing inside.
// Notes:   Carrier only.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.svh"
interface iep_req_if;
    logic [`IEP_NSRC-1:0] req;
    iep_pkg::iep_level_t prio [`IEP_NSRC];
    modport gate (output req, output prio);
    modport arb (input req, input prio);
endinterface
`default_nettype wire

// ==== iep_gate.sv ====
// Purpose: Qualify each pending request by its enable and priority.
// Assumes: Requests and enables come from logic on the same clock.
// Notes:   Priority code zero removes the source entirely.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.svh"
module iep_gate (
    input wire logic [`IEP_NSRC-1:0] req_i,
    input wire logic [`IEP_NSRC-1:0] enable_i,
    input wire iep_pkg::iep_level_t prio_i [`IEP_NSRC],
    iep_req_if.gate bus
);
    import iep_pkg::*;

    // Per-source gating of enable and non-zero level
    for (genvar g = 0; g < `IEP_NSRC; g++) begin : g_src
        assign bus.req[g] = req_i[g] & enable_i[g] &
                            (prio_i[g] != `IEP_PRI_OFF);
        assign bus.prio[g] = prio_i[g];
    end
endmodule
`default_nettype wire

// ==== iep_arb.sv ====
// Purpose: Pick the highest-level qualified request and register it.
// Assumes: Incoming requests are already gated.
// Notes:   Equal levels resolve to the lowest source number.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.svh"
module iep_arb (
    input wire logic clk_i,
    input wire logic rst_n_i,
    iep_req_if.arb bus,
    output logic irq_req_o,
    output iep_pkg::iep_level_t irq_level_o,
    output iep_pkg::iep_src_t irq_src_o
);
    import iep_pkg::*;

    logic win_any;
    iep_level_t win_lvl;
    iep_src_t win_src;
    logic req_q;
    iep_level_t lvl_q;
    iep_src_t src_q;

    // Strictly greater replaces, so ties keep the lower source
    always_comb begin
        win_any = 1'b0;
        win_lvl = `IEP_PRI_OFF;
        win_src = '0;
        for (int i = 0; i < `IEP_NSRC; i++) begin
            if (bus.req[i] && (bus.prio[i] > win_lvl)) begin
                win_any = 1'b1;
                win_lvl = bus.prio[i];
                win_src = 5'(i);
            end
        end
    end

    // Registered request, level and source towards the core
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q <= 1'b0;
            lvl_q <= `IEP_PRI_OFF;
            src_q <= '0;
        end else begin
            req_q <= win_any;
            lvl_q <= win_lvl;
            src_q <= win_src;
        end
    end

    assign irq_req_o = req_q;
    assign irq_level_o = lvl_q;
    assign irq_src_o = src_q;
endmodule
`default_nettype wire

// ==== iep_top.sv ====
// Purpose: Interrupt enable and priority registers with arbitration.
// Assumes: Request and external enable inputs come from logic on clk_i.
// Notes:   Read data stand only in the cycle after the read strobe.
// Contract
// - Enable bit set passes request, clear blocks
// - Enable word six holds only graphics bit
// - Enable word five bit one: serial3 error
// - Code 111 is level 7, highest
// - Code 001 lowest level, codes linear
// - Code 000 disables source regardless of enable
// - Unimplemented bits read zero, ignore writes
// - Reset: priorities 100, enables cleared
// - Priority word zero field placement
// - Priority word one field placement
// - Priority word two field placement
// - Priority word three: two low fields
// - Priority word four field placement
// - Enables read/write, each gates one source
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.svh"
module iep_top (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [`IEP_ADDR_W-1:0] addr_i,
    input wire logic [`IEP_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`IEP_DATA_W-1:0] rdata_o,
    input wire logic [`IEP_NSRC-1:0] req_i,
    input wire logic [`IEP_NSRC-1:0] ext_enable_i,
    input wire logic graphics_req_i,
    input wire logic serial3_error_req_i,
    output logic graphics_irq_enable_o,
    output logic serial3_error_irq_enable_o,
    output logic graphics_irq_req_o,
    output logic serial3_error_irq_req_o,
    output logic irq_req_o,
    output iep_pkg::iep_level_t irq_level_o,
    output iep_pkg::iep_src_t irq_src_o
);
    import iep_pkg::*;

    // ------------------------------------------------------------------
    // Register table
    // ------------------------------------------------------------------
    localparam logic [`IEP_ADDR_W-1:0] PRI_ADDR [`IEP_NPRI] = '{
        `IEP_OFS_PRI0, `IEP_OFS_PRI1, `IEP_OFS_PRI2,
        `IEP_OFS_PRI3, `IEP_OFS_PRI4};
    localparam logic [`IEP_DATA_W-1:0] PRI_MASK [`IEP_NPRI] = '{
        `IEP_MASK_PRI0, `IEP_MASK_PRI1, `IEP_MASK_PRI2,
        `IEP_MASK_PRI3, `IEP_MASK_PRI4};
    localparam logic [`IEP_DATA_W-1:0] PRI_RST [`IEP_NPRI] = '{
        `IEP_RST_PRI0, `IEP_RST_PRI1, `IEP_RST_PRI2,
        `IEP_RST_PRI3, `IEP_RST_PRI4};

    logic [`IEP_DATA_W-1:0] pri_q [`IEP_NPRI];
    logic [`IEP_NPRI-1:0] pri_wr;
    logic [`IEP_NPRI-1:0] pri_hit;
    logic ser3_err_en_q;
    logic gfx_en_q;
    logic [`IEP_DATA_W-1:0] rdata_q;
    logic [`IEP_DATA_W-1:0] rdata_d;
    logic [`IEP_DATA_W-1:0] pri_rd_word;
    logic [`IEP_DATA_W-1:0] ien_rd_word;
    logic hit_ien5;
    logic hit_ien6;
    logic wr_ien5;
    logic wr_ien6;
    iep_level_t prio [`IEP_NSRC];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Enable word strobes
    assign hit_ien5 = (addr_i == `IEP_OFS_IEN5);
    assign hit_ien6 = (addr_i == `IEP_OFS_IEN6);
    assign wr_ien5 = wr_i & hit_ien5;
    assign wr_ien6 = wr_i & hit_ien6;

    // Priority word strobes, one per word
    for (genvar g = 0; g < `IEP_NPRI; g++) begin : g_dec
        assign pri_hit[g] = (addr_i == PRI_ADDR[g]);
        assign pri_wr[g] = wr_i & pri_hit[g];
    end

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Only the implemented enable bits exist as flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ser3_err_en_q <= 1'b0;
            gfx_en_q <= 1'b0;
        end else begin
            if (wr_ien5) begin
                ser3_err_en_q <= wdata_i[`IEP_BIT_SER3_ERR];
            end
            if (wr_ien6) begin
                gfx_en_q <= wdata_i[`IEP_BIT_GFX];
            end
        end
    end

    // Priority words keep implemented bits only
    for (genvar g = 0; g < `IEP_NPRI; g++) begin : g_pri
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                pri_q[g] <= PRI_RST[g];
            end else if (pri_wr[g]) begin
                pri_q[g] <= wdata_i & PRI_MASK[g];
            end
        end
    end

    // ------------------------------------------------------------------
    // Field map from words to sources
    // ------------------------------------------------------------------
    // Word zero
    assign prio[IEP_EXT0] = pri_q[0][`IEP_FLD0_LSB +: 3];
    assign prio[IEP_CAPT1] = pri_q[0][`IEP_FLD1_LSB +: 3];
    assign prio[IEP_CMP1] = pri_q[0][`IEP_FLD2_LSB +: 3];
    assign prio[IEP_TMR1] = pri_q[0][`IEP_FLD3_LSB +: 3];
    // Word one
    assign prio[IEP_CAPT2] = pri_q[1][`IEP_FLD1_LSB +: 3];
    assign prio[IEP_CMP2] = pri_q[1][`IEP_FLD2_LSB +: 3];
    assign prio[IEP_TMR2] = pri_q[1][`IEP_FLD3_LSB +: 3];
    // Word two
    assign prio[IEP_TMR3] = pri_q[2][`IEP_FLD0_LSB +: 3];
    assign prio[IEP_SPORT1_FAULT] = pri_q[2][`IEP_FLD1_LSB +: 3];
    assign prio[IEP_SPORT1_EVT] = pri_q[2][`IEP_FLD2_LSB +: 3];
    assign prio[IEP_SER1_RX] = pri_q[2][`IEP_FLD3_LSB +: 3];
    // Word three
    assign prio[IEP_SER1_TX] = pri_q[3][`IEP_FLD0_LSB +: 3];
    assign prio[IEP_CONV_DONE] = pri_q[3][`IEP_FLD1_LSB +: 3];
    // Word four
    assign prio[IEP_I2C1_SLV] = pri_q[4][`IEP_FLD0_LSB +: 3];
    assign prio[IEP_I2C1_MST] = pri_q[4][`IEP_FLD1_LSB +: 3];
    assign prio[IEP_COMPARATOR] = pri_q[4][`IEP_FLD2_LSB +: 3];
    assign prio[IEP_CHANGE_NOTIFY] = pri_q[4][`IEP_FLD3_LSB +: 3];

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped offsets and unimplemented bits return zero
    always_comb begin
        pri_rd_word = '0;
        for (int i = 0; i < `IEP_NPRI; i++) begin
            if (pri_hit[i]) begin
                pri_rd_word = pri_q[i];
            end
        end
    end
    assign ien_rd_word =
        hit_ien5 ? (16'(ser3_err_en_q) << `IEP_BIT_SER3_ERR) :
        hit_ien6 ? (16'(gfx_en_q) << `IEP_BIT_GFX) : 16'h0000;
    assign rdata_d = rd_i ? (pri_rd_word | ien_rd_word) : 16'h0000;

    // Read data held for exactly the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // Enable outputs and gated requests
    // ------------------------------------------------------------------
    // Graphics and serial3 error requests pass only when enabled
    assign graphics_irq_enable_o = gfx_en_q;
    assign serial3_error_irq_enable_o = ser3_err_en_q;
    assign graphics_irq_req_o = graphics_req_i & gfx_en_q;
    assign serial3_error_irq_req_o = serial3_error_req_i &
                                     ser3_err_en_q;

    // ------------------------------------------------------------------
    // Qualification and arbitration
    // ------------------------------------------------------------------
    iep_req_if req_bus ();

    // Gate by the outer enable bits and the level code
    iep_gate u_gate (
        .req_i(req_i),
        .enable_i(ext_enable_i),
        .prio_i(prio),
        .bus(req_bus)
    );

    // Winner registered towards the core
    iep_arb u_arb (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .bus(req_bus),
        .irq_req_o(irq_req_o),
        .irq_level_o(irq_level_o),
        .irq_src_o(irq_src_o)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic top_pending;
    logic any_pending;

    // Any qualified request, and any at the top level
    always_comb begin
        top_pending = 1'b0;
        any_pending = 1'b0;
        for (int i = 0; i < `IEP_NSRC; i++) begin
            if (req_bus.req[i]) begin
                any_pending = 1'b1;
                if (req_bus.prio[i] == `IEP_PRI_TOP) begin
                    top_pending = 1'b1;
                end
            end
        end
    end

    sequence s_wr_pri0;
        wr_i && (addr_i == `IEP_OFS_PRI0);
    endsequence

    sequence s_rd_pri0;
        rd_i && (addr_i == `IEP_OFS_PRI0);
    endsequence

    property p_reset_vals;
        @(posedge clk_i)
        $rose(rst_n_i) |-> (pri_q[0] == `IEP_RST_PRI0) &&
            (pri_q[3] == `IEP_RST_PRI3) && !gfx_en_q && !ser3_err_en_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_unmapped_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_i && (addr_i > `IEP_OFS_PRI4) |=> (rdata_o == 16'h0000);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");

    property p_ien6_only_gfx;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_i && hit_ien6 |=>
            ((rdata_o & ~`IEP_MASK_IEN6) == 16'h0000) &&
            (rdata_o[`IEP_BIT_GFX] == gfx_en_q);
    endproperty
    a_ien6_only_gfx: assert property (p_ien6_only_gfx)
        else $error("enable six read wrong");

    property p_ien5_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_ien5 |=> (serial3_error_irq_enable_o ==
            $past(wdata_i[`IEP_BIT_SER3_ERR]));
    endproperty
    a_ien5_write: assert property (p_ien5_write)
        else $error("serial3 error enable not written");

    property p_gfx_block;
        @(posedge clk_i) disable iff (!rst_n_i)
        wr_ien6 && !wdata_i[`IEP_BIT_GFX] ##1 !wr_ien6 |->
            !graphics_irq_req_o;
    endproperty
    a_gfx_block: assert property (p_gfx_block)
        else $error("graphics request passed while disabled");

    property p_never_level0;
        @(posedge clk_i) disable iff (!rst_n_i)
        irq_req_o |-> (irq_level_o != `IEP_PRI_OFF);
    endproperty
    a_never_level0: assert property (p_never_level0)
        else $error("request presented at level zero");

    property p_top_wins;
        @(posedge clk_i) disable iff (!rst_n_i)
        top_pending |=> irq_req_o && (irq_level_o == `IEP_PRI_TOP);
    endproperty
    a_top_wins: assert property (p_top_wins)
        else $error("level seven request not forwarded");

    property p_idle;
        @(posedge clk_i) disable iff (!rst_n_i)
        !any_pending |=> !irq_req_o;
    endproperty
    a_idle: assert property (p_idle)
        else $error("request with nothing pending");

    property p_src_enabled;
        @(posedge clk_i) disable iff (!rst_n_i)
        irq_req_o |-> ($past(req_i & ext_enable_i) &
            (17'h00001 << irq_src_o)) != 17'h00000;
    endproperty
    a_src_enabled: assert property (p_src_enabled)
        else $error("disabled source forwarded");

    property p_level_match;
        @(posedge clk_i) disable iff (!rst_n_i)
        irq_req_o && (irq_src_o < 5'(`IEP_NSRC)) && $stable(pri_q[0]) &&
            $stable(pri_q[1]) && $stable(pri_q[2]) && $stable(pri_q[3]) &&
            $stable(pri_q[4]) |-> irq_level_o == prio[irq_src_o];
    endproperty
    a_level_match: assert property (p_level_match)
        else $error("level differs from field");

    property p_pri0_readback;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_wr_pri0 ##1 s_rd_pri0 |=>
            rdata_o == ($past(wdata_i, 2) & `IEP_MASK_PRI0);
    endproperty
    a_pri0_readback: assert property (p_pri0_readback)
        else $error("priority word zero readback wrong");
endmodule
`default_nettype wire

// ==== iep_core_model.sv ====
// Purpose: Core-side model that takes the presented interrupt request.
// Assumes: The core samples the request lines on every rising edge.
// Notes:   Keeps the last level and source it accepted.
`timescale 1ns/1ps
`default_nettype none
module iep_core_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic irq_req_i,
    input wire iep_pkg::iep_level_t irq_level_i,
    input wire iep_pkg::iep_src_t irq_src_i,
    output var iep_pkg::iep_level_t seen_level_o,
    output var iep_pkg::iep_src_t seen_src_o
);
    import iep_pkg::*;
    // Accept whatever request stands at the edge, no back-pressure
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_level_o <= 3'h0;
            seen_src_o <= 5'h00;
        end else if (irq_req_i) begin
            seen_level_o <= irq_level_i;
            seen_src_o <= irq_src_i;
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the enable and priority block.
// Assumes: All inputs change by non-blocking assignment at rising edges.
// Notes:   Expected values come from local shadow copies of the words.
`timescale 1ns/1ps
`default_nettype none
`include "iep_consts.svh"
module testbench;
    import iep_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic [16:0] req_i = '0;
    logic [16:0] ext_enable_i = '0;
    logic graphics_req_i = 1'b0;
    logic serial3_error_req_i = 1'b0;
    logic graphics_irq_enable_o, serial3_error_irq_enable_o;
    logic graphics_irq_req_o, serial3_error_irq_req_o, irq_req_o;
    iep_level_t irq_level_o, seen_level;
    iep_src_t irq_src_o, seen_src;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    integer seed = 32'h45fafceb;
    logic [15:0] pw [5];
    logic [15:0] ien [2];
    int fw [17] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4, 4};
    int fl [17] = '{0, 4, 8, 12, 4, 8, 12, 0, 4, 8, 12, 0, 4, 0, 4, 8, 12};

    iep_top i_iep_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .req_i(req_i), .ext_enable_i(ext_enable_i),
        .graphics_req_i(graphics_req_i),
        .serial3_error_req_i(serial3_error_req_i),
        .graphics_irq_enable_o(graphics_irq_enable_o),
        .serial3_error_irq_enable_o(serial3_error_irq_enable_o),
        .graphics_irq_req_o(graphics_irq_req_o),
        .serial3_error_irq_req_o(serial3_error_irq_req_o),
        .irq_req_o(irq_req_o), .irq_level_o(irq_level_o),
        .irq_src_o(irq_src_o));

    iep_core_model i_iep_core_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .irq_req_i(irq_req_o), .irq_level_i(irq_level_o),
        .irq_src_i(irq_src_o), .seen_level_o(seen_level),
        .seen_src_o(seen_src));

    // ------------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------------
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    // Cut the run short if the sequence stalls
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // Expectation helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] mask(input logic [3:0] a);
        case (a)
            4'h0: return `IEP_MASK_IEN5;
            4'h1: return `IEP_MASK_IEN6;
            4'h2: return `IEP_MASK_PRI0;
            4'h3: return `IEP_MASK_PRI1;
            4'h4: return `IEP_MASK_PRI2;
            4'h5: return `IEP_MASK_PRI3;
            4'h6: return `IEP_MASK_PRI4;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic logic [15:0] exp_reg(input logic [3:0] a);
        if (a < 4'h2) return ien[a];
        if (a < 4'h7) return pw[a - 4'h2];
        return 16'h0000;
    endfunction

    // Highest level wins, strict compare keeps the lowest source on ties
    function automatic logic [15:0] winner(input logic [16:0] r, e);
        logic [2:0] best;
        logic [4:0] who;
        logic [2:0] lv;
        best = 3'h0;
        who = 5'h00;
        for (int s = 0; s < 17; s++) begin
            lv = pw[fw[s]][fl[s] +: 3];
            if (r[s] && e[s] && lv > best) begin
                best = lv;
                who = s[4:0];
            end
        end
        return {7'h00, best != 3'h0, best, who};
    endfunction

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        if (a < 4'h2) ien[a] = d & mask(a);
        else if (a < 4'h7) pw[a - 4'h2] = d & mask(a);
    endtask

    // With nogap set the read strobe follows the previous strobe directly
    task automatic reg_chk(input logic [3:0] a, input bit nogap = 1'b0);
        if (!nogap) @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check($sformatf("word %0d", a), exp_reg(a), rdata_o);
    endtask

    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        pw = '{16'h4444, 16'h4440, 16'h4444, 16'h0044, 16'h4444};
        ien = '{16'h0000, 16'h0000};
        for (int a = 0; a < 16; a++) reg_chk(a[3:0]);
        $display("test reset_values done");
    endtask

    task automatic arb_case(input logic [16:0] r, e);
        logic [15:0] x;
        x = 16'h0000;
        @(posedge clk_i);
        req_i <= r;
        ext_enable_i <= e;
        repeat (2) @(posedge clk_i);
        x = winner(r, e);
        #1 check("winner", x, {7'h00, irq_req_o, irq_level_o, irq_src_o});
        if (x[8]) begin
            @(posedge clk_i);
            #1 check("core", x, {7'h00, 1'b1, seen_level, seen_src});
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] v;
        v = 16'h0000;
        do_reset();
        // All ones, all zeros and a random word into every offset
        for (int k = 0; k < 3; k++) begin
            for (int a = 0; a < 16; a++) begin
                v = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 :
                    16'($random(seed));
                reg_wr(a[3:0], v);
                reg_chk(a[3:0], 1'b1);
            end
        end
        $display("test register_map done");
        // Every enable and request pairing on the two gated sources
        for (int k = 0; k < 4; k++) begin
            reg_wr(`IEP_OFS_IEN5, {14'h0000, k[1], 1'b0});
            reg_wr(`IEP_OFS_IEN6, {11'h000, k[0], 4'h0});
            graphics_req_i <= k[1];
            serial3_error_req_i <= k[0];
            @(posedge clk_i);
            #1 check("gfx", k[1:0] & {2{k[0]}}, {graphics_irq_req_o, graphics_irq_enable_o});
            check("ser3", {k[1] & k[0], k[1]}, {serial3_error_irq_req_o, serial3_error_irq_enable_o});
        end
        $display("test enable_gating done");
        // Every priority code on all fields, then enables withheld
        for (int c = 0; c < 8; c++) begin
            v = {4{1'b0, c[2:0]}};
            for (int a = 2; a < 7; a++) reg_wr(a[3:0], v);
            arb_case('1, '1);
        end
        arb_case('1, '0);
        $display("test priority_codes done");
        // Random fields, requests and enables
        for (int n = 0; n < 40; n++) begin
            for (int a = 2; a < 7; a++) reg_wr(a[3:0], 16'($random(seed)));
            arb_case(17'($random(seed)), 17'($random(seed)));
        end
        $display("test random_arbitration done");
        // Reset in mid-run restores the defaults
        do_reset();
        arb_case(17'h00008, 17'h00008);
        complete_run();
    end
endmodule
`default_nettype wire
